// file: logic/ptimer_pkg.sv
package ptimer_pkg;

   // Register byte addresses (one aligned word each)
   localparam logic [4:0] ADDR_CTRL0 = 5'h00;
   localparam logic [4:0] ADDR_CTRL1 = 5'h04;
   localparam logic [4:0] ADDR_COUNT_LOW = 5'h08;
   localparam logic [4:0] ADDR_COUNT_HIGH = 5'h0c;
   localparam logic [4:0] ADDR_CMPA_LOW = 5'h10;
   localparam logic [4:0] ADDR_CMPA_HIGH = 5'h14;
   localparam logic [4:0] ADDR_CMPP_LOW = 5'h18;
   localparam logic [4:0] ADDR_CMPP_HIGH = 5'h1c;

   // Control register 0 fields
   localparam int CTRL0_PAUSE_BIT = 7;
   localparam int CTRL0_ENABLE_BIT = 3;
   localparam int CTRL0_PRESCALE_LSB = 4;

   // Control register 1 fields
   localparam int CTRL1_MODE_LSB = 6;
   localparam int CTRL1_PIN_LSB = 4;
   localparam int CTRL1_LEVEL_BIT = 3;
   localparam int CTRL1_INVERT_BIT = 2;
   localparam int CTRL1_RSVD_BIT = 1;
   localparam int CTRL1_CLEAR_BIT = 0;

   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [9:0] COUNT_RESET = 10'h000;
   localparam logic [9:0] COUNT_MAX = 10'h3ff;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0]
   {
      MODE_COMPARE = 2'b00,
      MODE_UNDEF = 2'b01,
      MODE_PWM = 2'b10,
      MODE_COUNTER = 2'b11
   } mode_t;

   typedef struct packed
   {
      mode_t mode_select;
      logic [1:0] pin_action_select;
      logic output_level_control;
      logic output_invert;
      logic reserved;
      logic clear_source_select;
   } ctrl1_t;

   typedef struct packed
   {
      logic match_a;
      logic match_p;
   } match_t;

endpackage

// file: logic/periodic_timer_control_regs.sv
//Contract
//- Mode 00 compare match, 10 PWM or single pulse, 11 timer/counter.
//- Timer/counter mode: level, invert and pin-action bits do not touch the pin.
//- Compare mode, A match: 00 hold, 01 low, 10 high, 11 toggle.
//- PWM group: 00 inactive, 01 active, 10 PWM, 11 single pulse.
//- Compare mode: requested level equal to initial level gives no visible change.
//- Enable rising edge returns the pin to its initial level.
//- Compare mode: level bit sets pin before any match, 0 low, 1 high.
//- PWM mode: level bit sets active level, 0 low, 1 high.
//- Single pulse: level bit is the level driven at enable rise.
//- Invert bit set inverts the output pin, clear passes it.
//- Clear source 1 clears on A match, 0 on P match or overflow.
//- Overflow clear only with clear source 0 and compare P all zero.
//- Clear source ignored in PWM and single pulse modes.
//- Counter read only as low byte and two-bit high byte.
//- Compare A held in read/write low and high bytes, reset zero.
//- Compare P held in read/write low and high bytes, reset zero.
//- Enable rise zeroes the counter; enable fall stops and keeps it.
//- Comparators A and P continuously compare counter and make match events, except A at compare A zero and P with clear source 1 outside PWM.
//- PWM: P match clears counter for period, A sets duty.
`timescale 1ns/1ns
module periodic_timer_control_regs
   import ptimer_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_tick,
   output logic timer_output_pin,
   output logic match_a_evt,
   output logic match_p_evt
);

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] ctrl0_q;
   ctrl1_t ctrl1_q;
   logic [9:0] count_q;
   logic [9:0] cmpa_q;
   logic [9:0] cmpp_q;
   logic [9:0] count_next;
   logic enable_q;
   logic enable_prev_q;
   logic tick_s1_q;
   logic tick_s2_q;
   logic tick_prev_q;
   logic pin_q;
   logic [4:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic wr_go;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] rd_byte;
   logic enable_rise;
   logic tick;
   logic run;
   match_t match;
   logic clear_cnt;
   logic sp_stop;
   mode_t mode;
   logic drive_level;
   logic pwm_active;

   assign mode = ctrl1_q.mode_select;
   assign enable_q = ctrl0_q[CTRL0_ENABLE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Write channel capture, either order
   assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         awaddr_q <= 5'h00;
      end
      else if (s_axi_awvalid && !aw_held_q)
      begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
      else if (wr_go)
         aw_held_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else if (s_axi_wvalid && !w_held_q)
      begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
      else if (wr_go)
         w_held_q <= 1'b0;
   end

   always_comb
   begin
      case (awaddr_q)
         ADDR_CTRL0, ADDR_CTRL1, ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
         ADDR_CMPA_LOW, ADDR_CMPA_HIGH, ADDR_CMPP_LOW, ADDR_CMPP_HIGH: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (wr_go)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes; single pulse A match drops the enable bit
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl0_q <= CTRL_RESET;
      else if (wr_go && awaddr_q == ADDR_CTRL0 && wstrb_q[0])
         ctrl0_q <= {wdata_q[7:3], 3'b000};
      else if (sp_stop)
         ctrl0_q[CTRL0_ENABLE_BIT] <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl1_q <= ctrl1_t'(CTRL_RESET);
      else if (wr_go && awaddr_q == ADDR_CTRL1 && wstrb_q[0])
         ctrl1_q <= ctrl1_t'(wdata_q[7:0]);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmpa_q <= COUNT_RESET;
         cmpp_q <= COUNT_RESET;
      end
      else if (wr_go && wstrb_q[0])
      begin
         case (awaddr_q)
            ADDR_CMPA_LOW: cmpa_q[7:0] <= wdata_q[7:0];
            ADDR_CMPA_HIGH: cmpa_q[9:8] <= wdata_q[1:0];
            ADDR_CMPP_LOW: cmpp_q[7:0] <= wdata_q[7:0];
            ADDR_CMPP_HIGH: cmpp_q[9:8] <= wdata_q[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_comb
   begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         ADDR_CTRL0: rd_byte = ctrl0_q;
         ADDR_CTRL1: rd_byte = ctrl1_q;
         ADDR_COUNT_LOW: rd_byte = count_q[7:0];
         ADDR_COUNT_HIGH: rd_byte = {6'h00, count_q[9:8]};
         ADDR_CMPA_LOW: rd_byte = cmpa_q[7:0];
         ADDR_CMPA_HIGH: rd_byte = {6'h00, cmpa_q[9:8]};
         ADDR_CMPP_LOW: rd_byte = cmpp_q[7:0];
         ADDR_CMPP_HIGH: rd_byte = {6'h00, cmpp_q[9:8]};
         default:
         begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && !s_axi_rvalid)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h000000, rd_byte};
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Timer clock tick: external level, synchronised then edge detected
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_prev_q <= 1'b0;
         enable_prev_q <= 1'b0;
      end
      else
      begin
         tick_s1_q <= timer_tick;
         tick_s2_q <= tick_s1_q;
         tick_prev_q <= tick_s2_q;
         enable_prev_q <= enable_q;
      end
   end

   assign tick = tick_s2_q && !tick_prev_q;
   assign enable_rise = enable_q && !enable_prev_q;
   assign run = enable_q && !ctrl0_q[CTRL0_PAUSE_BIT] && !enable_rise;

   ////////////////////////////////////////////////////////////////////////
   // Comparators and counter
   // Match on the value the next tick reaches, so the period equals compare P
   assign count_next = count_q + 10'h001;
   assign match.match_a = (count_next == cmpa_q);
   assign match.match_p = (count_next == cmpp_q);

   always_comb
   begin
      if (mode == MODE_PWM)
         clear_cnt = match.match_p && cmpp_q != COUNT_RESET;
      else if (ctrl1_q.clear_source_select)
         clear_cnt = match.match_a;
      else
         clear_cnt = match.match_p && cmpp_q != COUNT_RESET;
   end

   assign sp_stop = run && tick && mode == MODE_PWM && ctrl1_q.pin_action_select == 2'b11
                    && match.match_a;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_q <= COUNT_RESET;
      else if (enable_rise)
         count_q <= COUNT_RESET;
      else if (run && tick)
      begin
         if (clear_cnt)
            count_q <= COUNT_RESET;
         else
            count_q <= count_next;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         match_a_evt <= 1'b0;
         match_p_evt <= 1'b0;
      end
      else
      begin
         match_a_evt <= run && tick && match.match_a && cmpa_q != COUNT_RESET;
         match_p_evt <= run && tick && match.match_p && !(ctrl1_q.clear_source_select && mode != MODE_PWM);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output pin
   assign pwm_active = count_q < cmpa_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pin_q <= 1'b0;
      else if (enable_rise)
         pin_q <= ctrl1_q.output_level_control;
      else if (mode == MODE_COMPARE && run && tick && match.match_a && cmpa_q != COUNT_RESET)
      begin
         case (ctrl1_q.pin_action_select)
            2'b01: pin_q <= 1'b0;
            2'b10: pin_q <= 1'b1;
            2'b11: pin_q <= !pin_q;
            default: ;
         endcase
      end
      else if (mode == MODE_PWM && ctrl1_q.pin_action_select == 2'b11 && (sp_stop || !enable_q))
         pin_q <= !ctrl1_q.output_level_control;
   end

   always_comb
   begin
      case (mode)
         MODE_COMPARE: drive_level = pin_q;
         MODE_PWM:
         begin
            case (ctrl1_q.pin_action_select)
               2'b00: drive_level = !ctrl1_q.output_level_control;
               2'b01: drive_level = ctrl1_q.output_level_control;
               2'b10: drive_level = pwm_active ? ctrl1_q.output_level_control
                                               : !ctrl1_q.output_level_control;
               default: drive_level = pin_q;
            endcase
         end
         default: drive_level = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         timer_output_pin <= 1'b0;
      else if (mode == MODE_COUNTER || mode == MODE_UNDEF)
         timer_output_pin <= 1'b0;
      else
         timer_output_pin <= drive_level ^ ctrl1_q.output_invert;
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_enable_rise_zero;
      @(posedge aclk) disable iff (!aresetn) enable_rise |=> count_q == COUNT_RESET;
   endproperty
   a_enable_rise_zero: assert property (p_enable_rise_zero) else $error("Counter not zeroed");

   property p_hold_when_off;
      @(posedge aclk) disable iff (!aresetn) !enable_q && !enable_prev_q |=> $stable(count_q);
   endproperty
   a_hold_when_off: assert property (p_hold_when_off) else $error("Counter moved while off");

   property p_increment;
      @(posedge aclk) disable iff (!aresetn) run && tick && !clear_cnt |=> count_q == $past(count_q) + 10'h001;
   endproperty
   a_increment: assert property (p_increment) else $error("Counter did not step");

   property p_clear_a;
      @(posedge aclk) disable iff (!aresetn)
         run && tick && mode == MODE_COMPARE && ctrl1_q.clear_source_select && match.match_a
         |=> count_q == COUNT_RESET;
   endproperty
   a_clear_a: assert property (p_clear_a) else $error("A match did not clear");

   property p_no_p_clear_on_zero;
      @(posedge aclk) disable iff (!aresetn)
         run && tick && cmpp_q == COUNT_RESET && count_q == COUNT_RESET && cmpa_q != COUNT_RESET
         && !ctrl1_q.clear_source_select |=> count_q == 10'h001;
   endproperty
   a_no_p_clear_on_zero: assert property (p_no_p_clear_on_zero) else $error("Zero P cleared");

   property p_initial_level;
      @(posedge aclk) disable iff (!aresetn)
         enable_rise && mode == MODE_COMPARE && $stable(ctrl1_q)
         |=> ##1 timer_output_pin == (ctrl1_q.output_level_control ^ ctrl1_q.output_invert);
   endproperty
   a_initial_level: assert property (p_initial_level) else $error("Pin not at initial level");

   property p_counter_pin_low;
      @(posedge aclk) disable iff (!aresetn) mode == MODE_COUNTER |=> !timer_output_pin;
   endproperty
   a_counter_pin_low: assert property (p_counter_pin_low) else $error("Pin driven in counter mode");

   property p_force_active;
      @(posedge aclk) disable iff (!aresetn)
         mode == MODE_PWM && ctrl1_q.pin_action_select == 2'b01 && $stable(ctrl1_q)
         |=> timer_output_pin == ($past(ctrl1_q.output_level_control) ^ $past(ctrl1_q.output_invert));
   endproperty
   a_force_active: assert property (p_force_active) else $error("Forced active wrong");

   property p_count_high_read;
      @(posedge aclk) disable iff (!aresetn)
         s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == ADDR_COUNT_HIGH
         |=> s_axi_rvalid && s_axi_rdata[31:2] == 30'h0 && s_axi_rdata[1:0] == $past(count_q[9:8]);
   endproperty
   a_count_high_read: assert property (p_count_high_read) else $error("Counter high read wrong");

   c_pwm_period: cover property (@(posedge aclk) disable iff (!aresetn)
      mode == MODE_PWM && run && tick && clear_cnt);
   c_toggle: cover property (@(posedge aclk) disable iff (!aresetn)
      mode == MODE_COMPARE && ctrl1_q.pin_action_select == 2'b11 && match_a_evt);
   c_single_pulse_end: cover property (@(posedge aclk) disable iff (!aresetn) sp_stop);

endmodule // periodic_timer_control_regs

// file: verification/periodic_timer_control_regs_tb_top.sv
`timescale 1ns/1ns
module periodic_timer_control_regs_tb_top;
   import ptimer_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, pin, ma, mp, inv;
   logic [1:0] bresp, rresp;
   int fails, n_tests, cyc, na, np, a0, p0, n, hi;

   periodic_timer_control_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer_tick(tick), .timer_output_pin(pin), .match_a_evt(ma), .match_p_evt(mp));

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (ma === 1'b1) na <= na + 1;
      if (mp === 1'b1) np <= np + 1;
      if (cyc == 30000)
      begin
         fails = fails + 1;
         test_done;
      end
   end

   ////////////////////////////////////////////////////////////////////
   task test_done;
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", s, e, g);
      end
   endtask

   task chk_bit(input string s, input logic e, input logic g);
      n_tests++;
      if (g !== e)
      begin
         fails++;
         $display("unexpected %s: expected %b, seen %b", s, e, g);
      end
   endtask

   task wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
      logic da, dw, ta, tw;
      logic [1:0] rs;
      da = 1'b0;
      dw = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(da && dw))
      begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge aclk);
         if (ta)
         begin
            awvalid <= 1'b0;
            da = 1'b1;
         end
         if (tw)
         begin
            wvalid <= 1'b0;
            dw = 1'b1;
         end
      end
      bready <= 1'b1;
      do @(negedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
      @(posedge aclk);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, rs});
   endtask

   task rd(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta;
      logic [1:0] rs;
      logic [31:0] d;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(negedge aclk);
         ta = arready;
         @(posedge aclk);
      end
      while (ta !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(negedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      rready <= 1'b0;
      chk("rdata", e, d);
      chk("rresp", {30'h0, er}, {30'h0, rs});
   endtask

   // Ticks are held four cycles per level to pass the synchroniser
   task ticks(input int k);
      repeat (k)
      begin
         tick <= 1'b1;
         repeat (4) @(posedge aclk);
         tick <= 1'b0;
         repeat (4) @(posedge aclk);
      end
   endtask

   task pin_is(input logic e);
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk_bit("timer_output_pin", e, pin);
      @(posedge aclk);
   endtask

   function automatic logic [7:0] c1(logic [1:0] m, logic [1:0] p, logic l, logic i, logic c);
      return {m, p, l, i, 1'b0, c};
   endfunction

   function automatic logic cmp_level(logic [1:0] p, logic l);
      case (p)
         2'b00: return l;
         2'b01: return 1'b0;
         2'b10: return 1'b1;
         default: return ~l;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   initial
   begin
      {awvalid, wvalid, bready, arvalid, rready, tick, inv} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      {fails, n_tests, cyc, na, np} = '0;
      aresetn = 1'b0;
      v = $urandom(32'h4372);
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++) rd(5'(i * 4), 32'h0, RESP_OKAY);
      rd(5'h02, 32'h0, RESP_SLVERR);
      wr(5'h02, 8'h5a, RESP_SLVERR);
      for (int i = 0; i < 4; i++)
      begin
         v = $urandom;
         wr(5'(ADDR_CMPA_LOW + i[1] * 8), v[7:0], RESP_OKAY);
         wr(5'(ADDR_CMPA_HIGH + i[1] * 8), v[15:8], RESP_OKAY);
         rd(5'(ADDR_CMPA_LOW + i[1] * 8), {24'h0, v[7:0]}, RESP_OKAY);
         rd(5'(ADDR_CMPA_HIGH + i[1] * 8), {30'h0, v[9:8]}, RESP_OKAY);
      end
      for (int i = 0; i < 4; i++) wr(5'(ADDR_CMPA_LOW + i * 4), 8'h00, RESP_OKAY);
      wr(ADDR_COUNT_LOW, 8'hff, RESP_OKAY);
      rd(ADDR_COUNT_LOW, 32'h0, RESP_OKAY);
      // Counting, stop and restart
      n = 1 + $urandom % 30;
      wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
      ticks(n);
      rd(ADDR_COUNT_LOW, 32'(n), RESP_OKAY);
      wr(ADDR_CTRL0, 8'h00, RESP_OKAY);
      ticks(3);
      rd(ADDR_COUNT_LOW, 32'(n), RESP_OKAY);
      wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
      rd(ADDR_COUNT_LOW, 32'h0, RESP_OKAY);
      ticks(1026);
      rd(ADDR_COUNT_LOW, 32'h2, RESP_OKAY);
      rd(ADDR_COUNT_HIGH, 32'h0, RESP_OKAY);
      // Compare match pin actions, every code and level
      wr(ADDR_CMPA_LOW, 8'h03, RESP_OKAY);
      for (int k = 0; k < 8; k++)
      begin
         inv = 1'($urandom);
         wr(ADDR_CTRL0, 8'h00, RESP_OKAY);
         wr(ADDR_CTRL1, c1(MODE_COMPARE, k[2:1], k[0], inv, 1'b0), RESP_OKAY);
         wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
         pin_is(k[0] ^ inv);
         ticks(4);
         pin_is(cmp_level(k[2:1], k[0]) ^ inv);
      end
      wr(ADDR_CTRL0, 8'h00, RESP_OKAY);
      wr(ADDR_CTRL1, c1(MODE_COUNTER, 2'b11, 1'b1, 1'b1, 1'b0), RESP_OKAY);
      a0 = na;
      wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
      ticks(4);
      pin_is(1'b0);
      chk_bit("match_a_evt", 1'b1, na > a0);
      // Forced levels in the waveform mode
      for (int k = 0; k < 4; k++)
      begin
         inv = 1'($urandom);
         wr(ADDR_CTRL0, 8'h00, RESP_OKAY);
         wr(ADDR_CTRL1, c1(MODE_PWM, {1'b0, k[1]}, k[0], inv, 1'b1), RESP_OKAY);
         wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
         ticks(2);
         pin_is((k[1] ? k[0] : ~k[0]) ^ inv);
      end
      // Waveform: period 4, duty 2
      wr(ADDR_CTRL0, 8'h00, RESP_OKAY);
      wr(ADDR_CMPA_LOW, 8'h02, RESP_OKAY);
      wr(ADDR_CMPP_LOW, 8'h04, RESP_OKAY);
      wr(ADDR_CTRL1, c1(MODE_PWM, 2'b10, 1'b1, 1'b0, 1'b1), RESP_OKAY);
      p0 = np;
      hi = 0;
      wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
      repeat (8)
      begin
         ticks(1);
         repeat (2) @(posedge aclk);
         @(negedge aclk);
         hi += int'(pin === 1'b1);
         @(posedge aclk);
      end
      chk("active ticks", 32'd4, 32'(hi));
      chk("match_p count", 32'd2, 32'(np - p0));
      // Single pulse ends on A match
      wr(ADDR_CTRL0, 8'h00, RESP_OKAY);
      wr(ADDR_CMPA_LOW, 8'h03, RESP_OKAY);
      wr(ADDR_CTRL1, c1(MODE_PWM, 2'b11, 1'b1, 1'b0, 1'b0), RESP_OKAY);
      wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
      pin_is(1'b1);
      ticks(4);
      pin_is(1'b0);
      rd(ADDR_CTRL0, 32'h0, RESP_OKAY);
      // Clear source selection
      wr(ADDR_CMPP_LOW, 8'h01, RESP_OKAY);
      wr(ADDR_CTRL1, c1(MODE_COMPARE, 2'b00, 1'b0, 1'b0, 1'b1), RESP_OKAY);
      a0 = na;
      p0 = np;
      wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
      ticks(8);
      chk("match_p count", 32'd0, 32'(np - p0));
      chk_bit("match_a_evt", 1'b1, (na - a0) >= 2);
      wr(ADDR_CTRL0, 8'h00, RESP_OKAY);
      wr(ADDR_CMPP_LOW, 8'h02, RESP_OKAY);
      wr(ADDR_CTRL1, c1(MODE_COMPARE, 2'b00, 1'b0, 1'b0, 1'b0), RESP_OKAY);
      a0 = na;
      p0 = np;
      wr(ADDR_CTRL0, 8'h08, RESP_OKAY);
      ticks(8);
      chk("match_a count", 32'd0, 32'(na - a0));
      chk_bit("match_p_evt", 1'b1, (np - p0) >= 2);
      test_done;
   end
endmodule // periodic_timer_control_regs_tb_top
